//--- duc_pkg.sv
package duc_pkg;

    // Channel layout: four groups of eight outputs.
    localparam int NCH = 32;
    localparam int NGRP = 4;
    localparam int GRP_CH = 8;
    localparam int CW = 16;
    localparam int TMR_W = 16;

    // Register defaults; the reset sequence restores all but select, which only rst_i resets.
    localparam logic [CW-1:0] DEF_INPUT = 16'h5554;
    localparam logic [CW-1:0] DEF_GAIN = 16'hFFFF;
    localparam logic [CW-1:0] DEF_OFFSET = 16'h8000;
    localparam logic [GRP_CH-1:0] DEF_SELECT = 8'h00;
    localparam logic signed [18:0] CAL_BIAS = 19'sh08000;
    localparam logic [CW-1:0] CODE_MAX = 16'hFFFF;

    // Times in their own units and the clock rate.
    localparam int CLK_MHZ = 125;
    localparam int CALC_NS = 600;
    localparam int TAIL_NS = 300;
    localparam int SELECT_NS = 500;
    localparam int RESET_US = 300;

    // Cycle counts; tail and select times round down.
    localparam logic [TMR_W-1:0] CALC_CYC = TMR_W'(CALC_NS * CLK_MHZ / 1000);
    localparam logic [TMR_W-1:0] TAIL_CYC = TMR_W'(TAIL_NS * CLK_MHZ / 1000);
    localparam logic [TMR_W-1:0] SELECT_CYC = TMR_W'(SELECT_NS * CLK_MHZ / 1000);
    localparam int RESET_CYC = RESET_US * CLK_MHZ;

    // Kind of register write and channel addressing modes.
    typedef enum logic [1:0] {KIND_INPUT, KIND_GAIN, KIND_OFFSET, KIND_SELECT} duc_kind_e;
    typedef enum logic [2:0] {ADDR_ONE, ADDR_GROUP, ADDR_SAME_0_3, ADDR_SAME_1_3, ADDR_ALL} duc_addr_e;

    // One register write request.
    typedef struct packed {
        duc_kind_e kind;
        logic side_b;
        duc_addr_e addr;
        logic [1:0] group;
        logic [2:0] chan;
        logic [CW-1:0] data;
    } duc_wr_s;

endpackage

//--- duc_timer.sv
`timescale 1ns/1ps
module duc_timer import duc_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [TMR_W-1:0] count_i,
    output logic running_o,
    output logic done_o
);

    logic [TMR_W-1:0] cnt_r;

    // Down counter; a load overrides the count in progress.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (load_i) begin
            cnt_r <= count_i;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - TMR_W'(1);
        end
    end

    // Done marks the last cycle of the loaded span.
    assign running_o = (cnt_r != '0);
    assign done_o = (cnt_r == TMR_W'(1));

endmodule

//--- duc_calc.sv
`timescale 1ns/1ps
module duc_calc import duc_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [CW-1:0] x_i,
    input wire logic [CW-1:0] gain_i,
    input wire logic [CW-1:0] offset_i,
    output logic [CW-1:0] result_o
);

    logic [32:0] prod;
    logic [16:0] scaled;
    logic signed [18:0] sum;

    // Shared multiplier and adder: x * (m + 1) / 2^16 + c - 2^15.
    assign prod = 33'(x_i) * (33'(gain_i) + 33'd1);
    assign scaled = prod[32:16];
    assign sum = $signed({2'b00, scaled}) + $signed({3'b000, offset_i}) - CAL_BIAS;

    // Result is clamped to the code range and held in a register.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            result_o <= DEF_INPUT;
        end else if (sum < 0) begin
            result_o <= '0;
        end else if (sum > $signed({3'b000, CODE_MAX})) begin
            result_o <= CODE_MAX;
        end else begin
            result_o <= sum[CW-1:0];
        end
    end

endmodule

//--- duc_top.sv
// Overview of operation
// - Reset pin rising edge restores input, gain, offset.
// - Reset sequence takes 300 us; writes then ignored.
// - Only rising edge of reset pin acts.
// - After reset outputs stay grounded until write+load.
// - Clear low switches all outputs to ground.
// - Load strobes ignored while clear is low.
// - Clear high restores held output register values.
// - Clear never alters input or output registers.
// - Each input, gain or offset write recomputes calibrated data; busy low.
// - Writes accepted while busy; outputs never updated.
// - Busy pin only pulled low, released when done.
// - Low shared busy line defers load strobe.
// - Load strobe low copies selected calibrated values.
// - Strobe fall during busy is stored, applied later.
// - Strobe held low updates whenever busy rises.
// - Select register write drives busy 500 ns.
// - Writes address 1, 3, 4, 8 or 32 channels.
// - One multiplier; channels computed one after another.
// - Group 0 is outputs 0-7, groups 1-3 rest.
// - Offset default 32768, gain default 65535.
// - Busy at most (channels+1)*600 ns plus 300 ns.
// - Output refreshed only if calibrated value rewritten.
// - Select bit 0 picks A, 1 picks B.
`timescale 1ns/1ps
module duc_top import duc_pkg::*; #(
    parameter int RESET_SEQ_CYCLES = RESET_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic output_zero_force_n_i,
    input wire logic output_load_strobe_n_i,
    input wire logic busy_line_i,
    input wire logic wr_valid_i,
    input wire duc_wr_s wr_i,
    output logic busy_o,
    output logic busy_oe_o,
    output logic out_ground_o,
    output logic [NCH-1:0][CW-1:0] out_code_o
);

    typedef enum {ST_IDLE, ST_RESET, ST_CALC, ST_TAIL} duc_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and control state.

    logic [CW-1:0] input_data_a_reg [NCH];
    logic [CW-1:0] input_data_b_reg [NCH];
    logic [CW-1:0] gain_reg [NCH];
    logic [CW-1:0] offset_reg [NCH];
    logic [CW-1:0] calibrated_a_reg [NCH];
    logic [CW-1:0] calibrated_b_reg [NCH];
    logic [GRP_CH-1:0] select_r [NGRP];
    logic [NCH-1:0] pend_a_r;
    logic [NCH-1:0] pend_b_r;
    logic [NCH-1:0] dirty_a_r;
    logic [NCH-1:0] dirty_b_r;
    logic [NCH-1:0] pend_a_nxt;
    logic [NCH-1:0] pend_b_nxt;
    logic [NCH-1:0] dirty_a_nxt;
    logic [NCH-1:0] dirty_b_nxt;
    duc_state_e state_r;
    duc_state_e state_nxt;
    logic [4:0] cur_idx_r;
    logic cur_side_r;
    logic reset_pin_prev_r;
    logic strobe_prev_r;
    logic load_pend_r;
    logic ground_hold_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin edges and write acceptance.

    logic seq_start;
    logic strobe_fall;
    logic wr_take;
    logic wr_data;
    logic [NCH-1:0] wr_mask;
    logic [NCH-1:0] grp_mask;
    logic [NCH-1:0] same_mask;

    // Only a low-to-high transition of the reset pin starts the sequence.
    assign seq_start = reset_pin_n_i & ~reset_pin_prev_r;
    assign strobe_fall = strobe_prev_r & ~output_load_strobe_n_i;
    // Writes during the reset sequence are dropped; writes while busy are taken.
    assign wr_take = wr_valid_i & (state_r != ST_RESET) & ~seq_start;
    assign wr_data = wr_take & (wr_i.kind != KIND_SELECT);

    // Address decode into a channel mask of 1, 3, 4, 8 or 32 channels.
    assign grp_mask = NCH'(8'hFF) << {wr_i.group, 3'b000};
    assign same_mask = {NGRP{8'h01 << wr_i.chan}};
    always_comb begin
        case (wr_i.addr)
            ADDR_ONE: wr_mask = NCH'(1) << {wr_i.group, wr_i.chan};
            ADDR_GROUP: wr_mask = grp_mask;
            ADDR_SAME_0_3: wr_mask = same_mask;
            ADDR_SAME_1_3: wr_mask = same_mask & {{(NCH-GRP_CH){1'b1}}, 8'h00};
            ADDR_ALL: wr_mask = {NCH{1'b1}};
            default: wr_mask = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared calculation engine and its timers.

    logic eng_load;
    logic [TMR_W-1:0] eng_count;
    logic eng_done;
    logic sel_running;
    logic sel_load;
    logic [CW-1:0] calc_x;
    logic [CW-1:0] calc_result;
    logic cal_we;
    logic [2*NCH-1:0] pend_left;
    logic pick_valid;
    logic [5:0] pick;

    // Lowest pending entry; bit 5 of the index is the B side.
    function automatic logic [5:0] first_set(input logic [2*NCH-1:0] v);
        logic [5:0] idx;
        idx = '0;
        for (int k = 2 * NCH - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = 6'(k);
            end
        end
        return idx;
    endfunction

    assign cal_we = (state_r == ST_CALC) & eng_done;
    assign pend_left = {pend_b_r, pend_a_r} & ~({{(2*NCH-1){1'b0}}, cal_we} << {cur_side_r, cur_idx_r});
    assign pick_valid = |pend_left;
    assign pick = first_set(pend_left);
    assign calc_x = cur_side_r ? input_data_b_reg[cur_idx_r] : input_data_a_reg[cur_idx_r];
    assign sel_load = wr_take & (wr_i.kind == KIND_SELECT);

    // One multiplier serves every channel in turn.
    duc_calc u_calc (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .x_i(calc_x),
        .gain_i(gain_reg[cur_idx_r]),
        .offset_i(offset_reg[cur_idx_r]),
        .result_o(calc_result)
    );

    duc_timer u_eng_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(eng_load),
        .count_i(eng_count),
        .running_o(),
        .done_o(eng_done)
    );

    duc_timer u_sel_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(sel_load),
        .count_i(SELECT_CYC),
        .running_o(sel_running),
        .done_o()
    );

    // Sequencer: 600 ns per channel, then a 300 ns tail before busy is released.
    always_comb begin
        state_nxt = state_r;
        eng_load = 1'b0;
        eng_count = CALC_CYC;
        case (state_r)
            ST_IDLE: begin
                if (pick_valid) begin
                    eng_load = 1'b1;
                    state_nxt = ST_CALC;
                end
            end
            ST_RESET: begin
                if (eng_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CALC: begin
                if (eng_done) begin
                    eng_load = 1'b1;
                    if (!pick_valid) begin
                        eng_count = TAIL_CYC;
                        state_nxt = ST_TAIL;
                    end
                end
            end
            ST_TAIL: begin
                if (eng_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (seq_start) begin
            eng_load = 1'b1;
            eng_count = TMR_W'(RESET_SEQ_CYCLES);
            state_nxt = ST_RESET;
        end
    end

    // Engine state and the channel being computed.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cur_idx_r <= '0;
            cur_side_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (eng_load && !seq_start && pick_valid) begin
                cur_idx_r <= pick[4:0];
                cur_side_r <= pick[5];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Busy pin and load strobe handling.

    logic own_busy;
    logic load_go;
    logic [NCH-1:0] upd;

    // The device is busy while computing, resetting or holding a select pulse.
    assign own_busy = (state_r != ST_IDLE) | sel_running | (|pend_a_r) | (|pend_b_r);
    // A low line from any device holds off the load; clear low blocks it without dropping a stored one.
    assign load_go = output_zero_force_n_i & busy_line_i & ~own_busy
                     & (load_pend_r | ~output_load_strobe_n_i);

    // Pending and dirty flags; a set in the clearing cycle wins.
    assign pend_a_nxt = (pend_a_r & ~(pend_left[NCH-1:0] ^ pend_a_r)) | ({NCH{wr_data & ~wr_i.side_b}} & wr_mask);
    assign pend_b_nxt = (pend_b_r & ~(pend_left[2*NCH-1:NCH] ^ pend_b_r)) | ({NCH{wr_data & wr_i.side_b}} & wr_mask);
    assign dirty_a_nxt = (load_go ? '0 : dirty_a_r) | ({NCH{cal_we & ~cur_side_r}} & (NCH'(1) << cur_idx_r));
    assign dirty_b_nxt = (load_go ? '0 : dirty_b_r) | ({NCH{cal_we & cur_side_r}} & (NCH'(1) << cur_idx_r));

    // Busy is only ever pulled low; the pin's data bit stays low.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            busy_oe_o <= 1'b0;
        end else begin
            busy_o <= 1'b0;
            busy_oe_o <= own_busy;
        end
    end

    // Pin history, stored load request and the flags above.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reset_pin_prev_r <= 1'b1;
            strobe_prev_r <= 1'b1;
            load_pend_r <= 1'b0;
            pend_a_r <= '0;
            pend_b_r <= '0;
            dirty_a_r <= '0;
            dirty_b_r <= '0;
        end else begin
            reset_pin_prev_r <= reset_pin_n_i;
            strobe_prev_r <= output_load_strobe_n_i;
            if (seq_start) begin
                load_pend_r <= 1'b0;
                pend_a_r <= '0;
                pend_b_r <= '0;
                dirty_a_r <= '0;
                dirty_b_r <= '0;
            end else begin
                load_pend_r <= (load_pend_r & ~load_go) | (strobe_fall & output_zero_force_n_i);
                pend_a_r <= pend_a_nxt;
                pend_b_r <= pend_b_nxt;
                dirty_a_r <= dirty_a_nxt;
                dirty_b_r <= dirty_b_nxt;
            end
        end
    end

    // Outputs sit at ground after reset until a rewritten value is loaded, and whenever clear is low.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ground_hold_r <= 1'b1;
            out_ground_o <= 1'b1;
        end else begin
            if (seq_start) begin
                ground_hold_r <= 1'b1;
            end else if (load_go && (|upd)) begin
                ground_hold_r <= 1'b0;
            end
            out_ground_o <= ~output_zero_force_n_i | ground_hold_r;
        end
    end

    // Select registers, one byte per group of eight outputs.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int g = 0; g < NGRP; g++) begin
                select_r[g] <= DEF_SELECT;
            end
        end else if (sel_load) begin
            select_r[wr_i.group] <= wr_i.data[GRP_CH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel registers.

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic sel_b;
        logic hit;
        logic cal_hit;

        // Bit i%8 of the group's select byte chooses A or B.
        assign sel_b = select_r[i / GRP_CH][i % GRP_CH];
        assign upd[i] = sel_b ? dirty_b_r[i] : dirty_a_r[i];
        assign hit = wr_data & wr_mask[i];
        assign cal_hit = cal_we & (cur_idx_r == 5'(i));

        // Input, gain and offset registers; the reset sequence restores defaults.
        always_ff @(posedge clock_i) begin
            if (rst_i || seq_start) begin
                input_data_a_reg[i] <= DEF_INPUT;
                input_data_b_reg[i] <= DEF_INPUT;
                gain_reg[i] <= DEF_GAIN;
                offset_reg[i] <= DEF_OFFSET;
            end else if (hit) begin
                case (wr_i.kind)
                    KIND_INPUT: begin
                        if (wr_i.side_b) begin
                            input_data_b_reg[i] <= wr_i.data;
                        end else begin
                            input_data_a_reg[i] <= wr_i.data;
                        end
                    end
                    KIND_GAIN: gain_reg[i] <= wr_i.data;
                    KIND_OFFSET: offset_reg[i] <= wr_i.data;
                    default: ;
                endcase
            end
        end

        // Calibrated registers take the engine result at the end of a channel slot.
        always_ff @(posedge clock_i) begin
            if (rst_i || seq_start) begin
                calibrated_a_reg[i] <= DEF_INPUT;
                calibrated_b_reg[i] <= DEF_INPUT;
            end else if (cal_hit && !cur_side_r) begin
                calibrated_a_reg[i] <= calc_result;
            end else if (cal_hit && cur_side_r) begin
                calibrated_b_reg[i] <= calc_result;
            end
        end

        // Output register; clear never touches it.
        always_ff @(posedge clock_i) begin
            if (rst_i || seq_start) begin
                out_code_o[i] <= DEF_INPUT;
            end else if (load_go && upd[i]) begin
                out_code_o[i] <= sel_b ? calibrated_b_reg[i] : calibrated_a_reg[i];
            end
        end
    end

endmodule

//--- duc_update_monitor.sv
`timescale 1ns/1ps
module duc_update_monitor import duc_pkg::*; #(
    parameter int RESET_SEQ_CYCLES = RESET_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic output_zero_force_n_i,
    input wire logic output_load_strobe_n_i,
    input wire logic busy_line_i,
    input wire logic wr_valid_i,
    input wire duc_wr_s wr_i,
    input wire logic busy_o,
    input wire logic busy_oe_o,
    input wire logic out_ground_o,
    input wire logic [NCH-1:0][CW-1:0] out_code_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Longest legal busy pulse: every channel queued, one spare slot, the tail and pipeline slack.
    localparam int BUSY_MAX = (NCH + 1) * int'(CALC_CYC) + int'(TAIL_CYC) + 4;

    // Counts consecutive busy cycles, so an overlong pulse is caught without a long delay range.
    int busy_len;
    always_ff @(posedge clock_i) begin
        if (rst_i || !busy_oe_o) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end

    // Counts down across the reset sequence so writes inside it are not judged.
    int seq_cnt;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            seq_cnt <= 0;
        end else if ($rose(reset_pin_n_i)) begin
            seq_cnt <= RESET_SEQ_CYCLES + 4;
        end else if (seq_cnt != 0) begin
            seq_cnt <= seq_cnt - 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequence, clear, busy line and write checks.
    a_reset_busy_up: assert property ($rose(reset_pin_n_i) |-> ##[1:3] busy_oe_o [*8])
        else $error("reset sequence did not hold busy");
    a_reset_seq_end: assert property (seq_cnt == 1 |-> ##[0:4] !busy_oe_o)
        else $error("busy not released after reset sequence");
    a_reset_out_dflt: assert property ($rose(reset_pin_n_i)
        |=> (out_code_o == {NCH{DEF_INPUT}}) ##1 out_ground_o)
        else $error("outputs not restored by reset sequence");
    a_clear_grounds: assert property (!output_zero_force_n_i |=> out_ground_o)
        else $error("clear low did not ground outputs");
    a_clear_no_load: assert property (!output_zero_force_n_i && !$rose(reset_pin_n_i)
        |=> $stable(out_code_o))
        else $error("output changed while clear low");
    a_line_low_hold: assert property (!busy_line_i && !$rose(reset_pin_n_i) |=> $stable(out_code_o))
        else $error("output changed while busy line low");
    a_busy_pull_low: assert property (busy_oe_o |-> busy_o == 1'b0)
        else $error("busy pin driven high");
    a_write_busy_up: assert property (wr_valid_i && seq_cnt == 0 && !$rose(reset_pin_n_i)
        |-> ##[1:2] busy_oe_o)
        else $error("write did not raise busy");
    a_busy_bounded: assert property (seq_cnt == 0 |-> busy_len <= BUSY_MAX)
        else $error("busy pulse too long");

    c_reset_pin: cover property ($rose(reset_pin_n_i));
    c_peer_busy: cover property (!busy_line_i && !busy_oe_o);
    c_clear_strobe: cover property ($fell(output_load_strobe_n_i) && !output_zero_force_n_i);
endmodule

bind duc_top duc_update_monitor #(.RESET_SEQ_CYCLES(RESET_SEQ_CYCLES)) u_mon (
    .clock_i(clock_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
    .output_zero_force_n_i(output_zero_force_n_i), .output_load_strobe_n_i(output_load_strobe_n_i),
    .busy_line_i(busy_line_i), .wr_valid_i(wr_valid_i), .wr_i(wr_i), .busy_o(busy_o),
    .busy_oe_o(busy_oe_o), .out_ground_o(out_ground_o), .out_code_o(out_code_o)
);

//--- duc_peer_model.sv
`timescale 1ns/1ps
module duc_peer_model (
    input wire logic busy_oe_i,
    input wire logic hold_i,
    output logic busy_line_o
);
    // Wired busy line with pull-up: low while this device or the peer device pulls it.
    assign busy_line_o = !(busy_oe_i || hold_i);
endmodule

//--- duc_tb.sv
`timescale 1ns/1ps
module tb import duc_pkg::*;;
    localparam int SEQ = 50;
    logic clock_i, rst_i, reset_pin_n_i, output_zero_force_n_i, output_load_strobe_n_i;
    logic peer_hold, busy_line_i, wr_valid_i, busy_o, busy_oe_o, out_ground_o;
    duc_wr_s wr_i;
    logic [NCH-1:0][CW-1:0] out_code_o;
    logic [CW-1:0] exp_code [NCH];
    int err_total, samples_checked, cyc, n;

    duc_top #(.RESET_SEQ_CYCLES(SEQ)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
        .output_zero_force_n_i(output_zero_force_n_i), .output_load_strobe_n_i(output_load_strobe_n_i),
        .busy_line_i(busy_line_i), .wr_valid_i(wr_valid_i), .wr_i(wr_i), .busy_o(busy_o),
        .busy_oe_o(busy_oe_o), .out_ground_o(out_ground_o), .out_code_o(out_code_o)
    );
    duc_peer_model peer (.busy_oe_i(busy_oe_o), .hold_i(peer_hold), .busy_line_o(busy_line_i));

    // Free-running clock and a ceiling on the run length.
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared driving and comparing tasks.
    task automatic step(int k = 1);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task automatic chk_out(string what);
        for (int i = 0; i < NCH; i++) chk(what, out_code_o[i], exp_code[i]);
    endtask
    task automatic write(duc_kind_e k, logic b, duc_addr_e a, logic [1:0] g, logic [2:0] c, logic [CW-1:0] d);
        wr_i = '{kind: k, side_b: b, addr: a, group: g, chan: c, data: d};
        wr_valid_i = 1'b1;
        step();
        wr_valid_i = 1'b0;
        // One idle cycle keeps the next write from raising valid in the same time step.
        step();
    endtask
    // Returns how many cycles the device held busy.
    task automatic wait_idle(output int len);
        len = 0;
        for (int i = 0; i < 3000 && (busy_oe_o !== 1'b0 || i < 2); i++) begin
            len += int'(busy_oe_o === 1'b1);
            step();
        end
    endtask
    task automatic load();
        output_load_strobe_n_i = 1'b0;
        step();
        output_load_strobe_n_i = 1'b1;
        step(2);
    endtask
    function automatic logic hit(duc_addr_e a, int g, int c, int i);
        case (a)
            ADDR_ONE: return i == g * GRP_CH + c;
            ADDR_GROUP: return i / GRP_CH == g;
            ADDR_SAME_0_3: return i % GRP_CH == c;
            ADDR_SAME_1_3: return i % GRP_CH == c && i >= GRP_CH;
            default: return 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic s_reset_pin();
        reset_pin_n_i = 1'b1;
        step(3);
        chk("reset busy", busy_oe_o, 1'b1);
        chk("busy data", busy_o, 1'b0);
        write(KIND_INPUT, 1'b0, ADDR_ONE, 2'd0, 3'd0, 16'h1111);
        reset_pin_n_i = 1'b0;
        step(SEQ);
        chk("reset done", busy_oe_o, 1'b0);
        load();
        chk_out("reset defaults");
        chk("ground hold", out_ground_o, 1'b1);
    endtask
    task automatic s_modes();
        int cnt;
        for (int m = 0; m < 5; m++) begin
            cnt = 0;
            write(KIND_INPUT, 1'b0, duc_addr_e'(m), 2'd1, 3'd2, CW'(16'h1000 + m * 16'h0111));
            wait_idle(n);
            for (int i = 0; i < NCH; i++) cnt += int'(hit(duc_addr_e'(m), 1, 2, i));
            chk("busy length", n >= cnt * CALC_CYC && n <= (cnt + 1) * CALC_CYC + TAIL_CYC, 1);
            chk_out("no load yet");
            load();
            for (int i = 0; i < NCH; i++) begin
                if (hit(duc_addr_e'(m), 1, 2, i)) begin
                    exp_code[i] = CW'(16'h1000 + m * 16'h0111);
                end
            end
            chk_out("addressed set");
        end
        chk("ground off", out_ground_o, 1'b0);
    endtask
    task automatic s_trim();
        write(KIND_GAIN, 1'b0, ADDR_ONE, 2'd0, 3'd0, 16'h7FFF);
        write(KIND_OFFSET, 1'b0, ADDR_ONE, 2'd0, 3'd0, 16'h8010);
        wait_idle(n);
        peer_hold = 1'b1;
        load();
        chk("deferred", out_code_o[0], exp_code[0]);
        peer_hold = 1'b0;
        step(3);
        exp_code[0] = (exp_code[0] >> 1) + 16'h0010;
        chk_out("trimmed");
    endtask
    task automatic s_clear();
        write(KIND_INPUT, 1'b0, ADDR_ONE, 2'd0, 3'd1, 16'h2222);
        wait_idle(n);
        output_zero_force_n_i = 1'b0;
        load();
        chk("clear ground", out_ground_o, 1'b1);
        chk_out("clear ignores load");
        output_zero_force_n_i = 1'b1;
        step(2);
        chk("clear off", out_ground_o, 1'b0);
        chk_out("clear restores");
        load();
        exp_code[1] = 16'h2222;
        chk_out("after clear");
    endtask
    task automatic s_select();
        write(KIND_INPUT, 1'b1, ADDR_ONE, 2'd0, 3'd3, 16'h3333);
        wait_idle(n);
        write(KIND_SELECT, 1'b0, ADDR_ONE, 2'd0, 3'd0, 16'h0008);
        wait_idle(n);
        chk("select busy", n >= SELECT_CYC - 2 && n <= SELECT_CYC + 4, 1);
        load();
        exp_code[3] = 16'h3333;
        chk_out("b side");
        output_load_strobe_n_i = 1'b0;
        write(KIND_INPUT, 1'b1, ADDR_ONE, 2'd0, 3'd3, 16'h3456);
        wait_idle(n);
        step(2);
        exp_code[3] = 16'h3456;
        chk_out("strobe held");
        output_load_strobe_n_i = 1'b1;
    endtask
    task automatic s_second_reset();
        write(KIND_INPUT, 1'b0, ADDR_ONE, 2'd0, 3'd0, 16'h4321);
        load();
        reset_pin_n_i = 1'b1;
        step(SEQ + 8);
        foreach (exp_code[i]) exp_code[i] = DEF_INPUT;
        chk_out("second reset");
        chk("second ground", out_ground_o, 1'b1);
        chk("second idle", busy_oe_o, 1'b0);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        rst_i = 1'b1;
        reset_pin_n_i = 1'b0;
        output_zero_force_n_i = 1'b1;
        output_load_strobe_n_i = 1'b1;
        peer_hold = 1'b0;
        wr_valid_i = 1'b0;
        wr_i = '0;
        foreach (exp_code[i]) exp_code[i] = DEF_INPUT;
        step(6);
        rst_i = 1'b0;
        step(2);
        s_reset_pin();
        s_modes();
        s_trim();
        s_clear();
        s_select();
        s_second_reset();
        print_verdict();
    end
endmodule
